// ===== cbs_pkg.sv
// shared constants for the bus cycle sequencer
package cbs_pkg;
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  localparam logic [15:0] VEC_SWI_HI = 16'hFFFA;
  localparam logic [15:0] VEC_SWI_LO = 16'hFFFB;
  localparam logic [7:0] WO_READ_VALUE = 8'hFF;
  localparam logic [15:0] RET_OFS_ONE = 16'h0001;
  localparam logic [15:0] RET_OFS_TWO = 16'h0002;
  localparam logic [3:0] CYC_FIRST = 4'h1;
  localparam logic [3:0] CYC_DUMMY = 4'h2;
  localparam logic [3:0] CYC_PUSH_FIRST = 4'h3;
  localparam logic [3:0] CYC_PUSH_LAST = 4'h9;
  localparam logic [3:0] CYC_VEC_HI = 4'hA;
  localparam logic [3:0] CYC_VEC_LO = 4'hB;
  localparam logic [3:0] CYC_SWI_LAST = 4'hC;
  localparam logic [3:0] CYC_BRA_LAST = 4'h3;
  localparam logic [3:0] CYC_BSR_LAST = 4'h5;
  localparam logic [1:0] KIND_SWI = 2'h0;
  localparam logic [1:0] KIND_WAI = 2'h1;
  localparam logic [1:0] KIND_BRA = 2'h2;
  localparam logic [1:0] KIND_BSR = 2'h3;
  localparam int CLK_HZ = 100000000;
  localparam int RX_BAUD = 115200;
  localparam int RX_OVERSAMPLE = 16;
  localparam int RX_TICK_DIV_I = CLK_HZ / (RX_BAUD * RX_OVERSAMPLE);
  localparam logic [15:0] RX_TICK_DIV = RX_TICK_DIV_I[15:0];
  localparam logic [3:0] RX_MID_TICK = 4'h7;
  localparam logic [3:0] RX_LAST_TICK = 4'hF;
  localparam logic [3:0] RX_DATA_BITS = 4'h8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SWI = 6'b000010,
    ST_WAI = 6'b000100,
    ST_WAITI = 6'b001000,
    ST_BRA = 6'b010000,
    ST_BSR = 6'b100000
  } cbs_state_t;
endpackage : cbs_pkg

// ===== cbs_rx_sampler.sv
// serial receiver sampling each bit at its centre on a 16x tick
`timescale 1ns/1ps
module cbs_rx_sampler (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic tick_en,
  input wire logic rxd,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err
);
  logic active_ff;
  logic [3:0] tick_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [7:0] data_ff;
  logic valid_ff;
  logic ferr_ff;
  logic mid;

  // centre sampling, start re-synchronised on each frame's falling edge
  assign mid = tick_en && (tick_ff == cbs_pkg::RX_MID_TICK);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_ff <= 1'b0;
      tick_ff <= 4'h0;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else if (!active_ff) begin
      tick_ff <= 4'h0;
      bit_ff <= 4'h0;
      if (tick_en && !rxd) begin
        active_ff <= 1'b1;
      end
    end else if (tick_en) begin
      tick_ff <= tick_ff + 4'h1;
      if (mid) begin
        if (bit_ff == 4'h0 && rxd) begin
          active_ff <= 1'b0;
        end else if (bit_ff == cbs_pkg::RX_DATA_BITS + 4'h1) begin
          active_ff <= 1'b0;
        end else if (bit_ff != 4'h0) begin
          shift_ff <= {rxd, shift_ff[7:1]};
        end
        bit_ff <= bit_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_ff <= 8'h00;
      valid_ff <= 1'b0;
      ferr_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      if (active_ff && mid && bit_ff == cbs_pkg::RX_DATA_BITS + 4'h1) begin
        data_ff <= shift_ff;
        valid_ff <= rxd;
        ferr_ff <= !rxd;
      end
    end
  end

  assign rx_data = data_ff;
  assign rx_valid = valid_ff;
  assign rx_frame_err = ferr_ff;
endmodule : cbs_rx_sampler

// ===== cbs_sequencer.sv
// bus cycle sequencer for interrupt, branch and subroutine instructions
`timescale 1ns/1ps
module cbs_sequencer (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_input_n,
  input wire logic osc_running,
  input wire logic start,
  input wire logic [1:0] instr_kind,
  input wire logic branch_test,
  input wire logic halt,
  input wire logic irq_req,
  input wire logic [15:0] irq_vec_addr,
  input wire logic [15:0] op_addr,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] x_in,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [7:0] ccr_in,
  input wire logic [7:0] data_in,
  input wire logic rd_write_only,
  input wire logic rxd,
  output logic [15:0] addr,
  output logic [7:0] data_out,
  output logic rw,
  output logic rd_n,
  output logic wr_n,
  output logic opcode_fetch_strobe_n,
  output logic busy,
  output logic wai_waiting,
  output logic [7:0] cpu_rdata,
  output logic core_reset_n,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err
);
  cbs_pkg::cbs_state_t state_ff, nxt_state;
  logic [3:0] cyc_ff, nxt_cyc;
  logic [15:0] op_ff, sp_ff, x_ff, vec_ff;
  logic [7:0] a_ff, b_ff, ccr_ff, ofs_ff, vhi_ff;
  logic taken_ff;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] dout_ff, nxt_dout, rdata_ff;
  logic rw_ff, nxt_rw, rd_n_ff, nxt_rd_n, wr_n_ff, nxt_wr_n, lir_n_ff, nxt_lir_n;
  logic res_meta_ff, res_sync_ff, osc_ok_ff, core_rst_n_ff;
  logic [15:0] div_ff;
  logic rx_tick;
  logic [7:0] din;
  logic [15:0] ret_addr, target;

  // all-ones answer for write-only locations, used for every read
  function automatic logic [7:0] read_value(input logic wo, input logic [7:0] d);
    read_value = wo ? cbs_pkg::WO_READ_VALUE : d;
  endfunction : read_value

  function automatic logic [7:0] push_byte(input logic [3:0] n, input logic [15:0] ret,
                                           input logic [15:0] x, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] c);
    case (n)
      4'h0: push_byte = ret[7:0];
      4'h1: push_byte = ret[15:8];
      4'h2: push_byte = x[7:0];
      4'h3: push_byte = x[15:8];
      4'h4: push_byte = a;
      4'h5: push_byte = b;
      default: push_byte = c;
    endcase
  endfunction : push_byte

  assign din = read_value(rd_write_only, data_in);
  assign ret_addr = op_ff + ((state_ff == cbs_pkg::ST_BSR) ? cbs_pkg::RET_OFS_TWO
                                                          : cbs_pkg::RET_OFS_ONE);
  assign target = op_ff + cbs_pkg::RET_OFS_TWO + {{8{ofs_ff[7]}}, ofs_ff};

  // reset sampled on the clock, taken only once the oscillator runs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_meta_ff <= 1'b0;
      res_sync_ff <= 1'b0;
      osc_ok_ff <= 1'b0;
      core_rst_n_ff <= 1'b0;
    end else begin
      res_meta_ff <= reset_input_n;
      res_sync_ff <= res_meta_ff;
      osc_ok_ff <= osc_running;
      if (osc_ok_ff) begin
        core_rst_n_ff <= res_sync_ff;
      end
    end
  end

  // sequence control
  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff + 4'h1;
    unique case (state_ff)
      cbs_pkg::ST_IDLE: begin
        nxt_cyc = cbs_pkg::CYC_FIRST;
        if (start && !halt && core_rst_n_ff) begin
          unique case (instr_kind)
            cbs_pkg::KIND_SWI: nxt_state = cbs_pkg::ST_SWI;
            cbs_pkg::KIND_WAI: nxt_state = cbs_pkg::ST_WAI;
            cbs_pkg::KIND_BRA: nxt_state = cbs_pkg::ST_BRA;
            cbs_pkg::KIND_BSR: nxt_state = cbs_pkg::ST_BSR;
          endcase
        end
      end
      cbs_pkg::ST_SWI: begin
        if (cyc_ff == cbs_pkg::CYC_SWI_LAST) begin
          nxt_state = cbs_pkg::ST_IDLE;
        end
      end
      cbs_pkg::ST_WAI: begin
        if (cyc_ff == cbs_pkg::CYC_PUSH_LAST) begin
          nxt_state = cbs_pkg::ST_WAITI;
        end
      end
      cbs_pkg::ST_WAITI: begin
        // halt is not looked at here; the system keeps it off
        nxt_cyc = cyc_ff;
        if (irq_req) begin
          nxt_state = cbs_pkg::ST_SWI;
          nxt_cyc = cbs_pkg::CYC_VEC_HI;
        end
      end
      cbs_pkg::ST_BRA: begin
        if (cyc_ff == cbs_pkg::CYC_BRA_LAST) begin
          nxt_state = cbs_pkg::ST_IDLE;
        end
      end
      cbs_pkg::ST_BSR: begin
        if (cyc_ff == cbs_pkg::CYC_BSR_LAST) begin
          nxt_state = cbs_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= cbs_pkg::ST_IDLE;
      cyc_ff <= 4'h0;
    end else if (!core_rst_n_ff) begin
      state_ff <= cbs_pkg::ST_IDLE;
      cyc_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= (nxt_state == cbs_pkg::ST_IDLE) ? 4'h0 : nxt_cyc;
    end
  end

  // operand capture: registers at start, offset and vector from reads
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      op_ff <= 16'h0000;
      sp_ff <= 16'h0000;
      x_ff <= 16'h0000;
      vec_ff <= cbs_pkg::VEC_SWI_HI;
      a_ff <= 8'h00;
      b_ff <= 8'h00;
      ccr_ff <= 8'h00;
      taken_ff <= 1'b0;
      ofs_ff <= 8'h00;
      vhi_ff <= 8'h00;
    end else begin
      if (state_ff == cbs_pkg::ST_IDLE && nxt_state != cbs_pkg::ST_IDLE) begin
        op_ff <= op_addr;
        sp_ff <= sp_in;
        x_ff <= x_in;
        a_ff <= acc_a;
        b_ff <= acc_b;
        ccr_ff <= ccr_in;
        taken_ff <= branch_test;
        vec_ff <= cbs_pkg::VEC_SWI_HI;
      end
      if (state_ff == cbs_pkg::ST_WAITI && irq_req) begin
        vec_ff <= irq_vec_addr;
      end
      if ((state_ff == cbs_pkg::ST_BRA || state_ff == cbs_pkg::ST_BSR) &&
          cyc_ff == cbs_pkg::CYC_FIRST) begin
        ofs_ff <= din;
      end
      if (state_ff == cbs_pkg::ST_SWI && cyc_ff == cbs_pkg::CYC_VEC_HI) begin
        vhi_ff <= din;
      end
    end
  end

  // bus values for the cycle about to be driven
  always_comb begin
    nxt_addr = cbs_pkg::DUMMY_ADDR;
    nxt_dout = dout_ff;
    nxt_rw = 1'b1;
    nxt_rd_n = 1'b1;
    nxt_wr_n = 1'b1;
    nxt_lir_n = 1'b1;
    if (core_rst_n_ff && nxt_state != cbs_pkg::ST_IDLE && nxt_state != cbs_pkg::ST_WAITI) begin
      if (nxt_cyc == cbs_pkg::CYC_FIRST) begin
        nxt_addr = op_addr + cbs_pkg::RET_OFS_ONE;
        nxt_rd_n = 1'b0;
      end else if (nxt_cyc == cbs_pkg::CYC_DUMMY) begin
        nxt_addr = cbs_pkg::DUMMY_ADDR;
      end else if (nxt_state == cbs_pkg::ST_BRA) begin
        nxt_addr = taken_ff ? target : op_ff + cbs_pkg::RET_OFS_TWO;
        nxt_rd_n = 1'b0;
        nxt_lir_n = 1'b0;
      end else if (nxt_state == cbs_pkg::ST_BSR && nxt_cyc == cbs_pkg::CYC_BSR_LAST) begin
        nxt_addr = target;
        nxt_rd_n = 1'b0;
        nxt_lir_n = 1'b0;
      end else if (nxt_cyc <= cbs_pkg::CYC_PUSH_LAST) begin
        nxt_addr = sp_ff - {12'h000, nxt_cyc - cbs_pkg::CYC_PUSH_FIRST};
        nxt_dout = push_byte(nxt_cyc - cbs_pkg::CYC_PUSH_FIRST, ret_addr, x_ff,
                             a_ff, b_ff, ccr_ff);
        nxt_rw = 1'b0;
        nxt_wr_n = 1'b0;
      end else if (nxt_cyc == cbs_pkg::CYC_VEC_HI) begin
        nxt_addr = (state_ff == cbs_pkg::ST_WAITI) ? irq_vec_addr : vec_ff;
        nxt_rd_n = 1'b0;
      end else if (nxt_cyc == cbs_pkg::CYC_VEC_LO) begin
        nxt_addr = vec_ff + cbs_pkg::RET_OFS_ONE;
        nxt_rd_n = 1'b0;
      end else begin
        nxt_addr = {vhi_ff, din};
        nxt_rd_n = 1'b0;
        nxt_lir_n = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= cbs_pkg::DUMMY_ADDR;
      dout_ff <= 8'h00;
      rw_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      lir_n_ff <= 1'b1;
      rdata_ff <= 8'h00;
    end else begin
      addr_ff <= nxt_addr;
      dout_ff <= nxt_dout;
      rw_ff <= nxt_rw;
      rd_n_ff <= nxt_rd_n;
      wr_n_ff <= nxt_wr_n;
      lir_n_ff <= nxt_lir_n;
      if (!rd_n_ff) begin
        rdata_ff <= din;
      end
    end
  end

  // 16x receive tick divider
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 16'h0000;
    end else if (div_ff == cbs_pkg::RX_TICK_DIV - 16'h0001) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign rx_tick = (div_ff == cbs_pkg::RX_TICK_DIV - 16'h0001);

  cbs_rx_sampler u_rx (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick_en(rx_tick),
    .rxd(rxd),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_frame_err(rx_frame_err)
  );

  assign addr = addr_ff;
  assign data_out = dout_ff;
  assign rw = rw_ff;
  assign rd_n = rd_n_ff;
  assign wr_n = wr_n_ff;
  assign opcode_fetch_strobe_n = lir_n_ff;
  assign busy = (state_ff != cbs_pkg::ST_IDLE);
  assign wai_waiting = (state_ff == cbs_pkg::ST_WAITI);
  assign cpu_rdata = rdata_ff;
  assign core_reset_n = core_rst_n_ff;
endmodule : cbs_sequencer

// ===== cbs_mem_model.sv
// memory and peripheral model on the far side of the bus
`timescale 1ns/1ps
module cbs_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] addr,
  input wire logic [7:0] data_out,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] data_in,
  output logic rd_write_only
);
  logic [7:0] wo_ff = 8'h3C;
  logic [7:0] last_ff = 8'h00;
  logic [7:0] rom;
  always_comb begin
    case (addr)
      16'hFFFA: rom = 8'h12;
      16'hFFFB: rom = 8'h34;
      default: rom = addr[7:0] ^ 8'hA5;
    endcase
  end
  // page 40 holds write-only places; stored value starts at 3C and takes any byte written there
  assign rd_write_only = !rd_n && (addr[15:8] == 8'h40);
  // released bus shows the inverse of the last value
  assign data_in = rd_n ? ~last_ff : (rd_write_only ? wo_ff : rom);
  always @(posedge clk_sys) begin
    if (!rd_n) last_ff <= data_in;
    if (!wr_n && addr[15:8] == 8'h40) wo_ff <= data_out;
  end
endmodule : cbs_mem_model

// ===== cbs_sequencer_assertions.sv
// checker for the bus cycle sequencer
`timescale 1ns/1ps
module cbs_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reset_input_n,
  input wire logic osc_running,
  input wire logic start,
  input wire logic [1:0] instr_kind,
  input wire logic halt,
  input wire logic irq_req,
  input wire logic [15:0] irq_vec_addr,
  input wire logic [15:0] sp_in,
  input wire logic rd_write_only,
  input wire logic [15:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic opcode_fetch_strobe_n,
  input wire logic busy,
  input wire logic wai_waiting,
  input wire logic [7:0] cpu_rdata,
  input wire logic core_reset_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic take;
  assign take = start && !halt && !busy && core_reset_n;
  property p_swi_push;
    take && instr_kind == cbs_pkg::KIND_SWI |-> ##3 (!wr_n)[*7] ##1 wr_n;
  endproperty
  a_swi_push: assert property (p_swi_push) else $error("swi push count wrong");
  property p_swi_vec;
    take && instr_kind == cbs_pkg::KIND_SWI |-> ##10 (addr == cbs_pkg::VEC_SWI_HI && !rd_n
      && opcode_fetch_strobe_n) ##1 (addr == cbs_pkg::VEC_SWI_LO && !rd_n && opcode_fetch_strobe_n);
  endproperty
  a_swi_vec: assert property (p_swi_vec) else $error("swi vector read wrong");
  property p_swi_fetch;
    take && instr_kind == cbs_pkg::KIND_SWI |-> ##12 (!opcode_fetch_strobe_n && !rd_n) ##1 !busy;
  endproperty
  a_swi_fetch: assert property (p_swi_fetch) else $error("swi handler fetch wrong");
  property p_bra;
    take && instr_kind == cbs_pkg::KIND_BRA |-> ##2 (addr == cbs_pkg::DUMMY_ADDR && rd_n && wr_n
      && opcode_fetch_strobe_n) ##1 (!rd_n && !opcode_fetch_strobe_n);
  endproperty
  a_bra: assert property (p_bra) else $error("branch cycles wrong");
  property p_bsr;
    take && instr_kind == cbs_pkg::KIND_BSR |-> ##3 (!wr_n && addr == $past(sp_in, 3))
      ##1 (!wr_n && addr == $past(sp_in, 4) - 16'h0001) ##1 !opcode_fetch_strobe_n;
  endproperty
  a_bsr: assert property (p_bsr) else $error("subroutine branch cycles wrong");
  property p_wo;
    !rd_n && rd_write_only |=> cpu_rdata == cbs_pkg::WO_READ_VALUE;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only read not all ones");
  property p_wai_hold;
    wai_waiting && !irq_req |=> wai_waiting && busy;
  endproperty
  a_wai_hold: assert property (p_wai_hold) else $error("wait left without irq");
  property p_wai_vec;
    wai_waiting && irq_req |-> ##[1:2] (addr == irq_vec_addr && !rd_n);
  endproperty
  a_wai_vec: assert property (p_wai_vec) else $error("wait vector read missing");
  property p_osc;
    !osc_running |=> $stable(core_reset_n);
  endproperty
  a_osc: assert property (p_osc) else $error("reset moved without oscillator");
  property p_rst_sync;
    (!reset_input_n && osc_running)[*3] |=> !core_reset_n;
  endproperty
  a_rst_sync: assert property (p_rst_sync) else $error("internal reset not applied");
endmodule : cbs_checker
bind cbs_sequencer cbs_checker i_chk (.clk_sys(clk_sys), .nrst(nrst),
  .reset_input_n(reset_input_n), .osc_running(osc_running), .start(start),
  .instr_kind(instr_kind), .halt(halt), .irq_req(irq_req), .irq_vec_addr(irq_vec_addr),
  .sp_in(sp_in), .rd_write_only(rd_write_only), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
  .opcode_fetch_strobe_n(opcode_fetch_strobe_n), .busy(busy), .wai_waiting(wai_waiting),
  .cpu_rdata(cpu_rdata), .core_reset_n(core_reset_n));

// ===== cpu_bus_cycle_sequencer_test.sv
// testbench for the bus cycle sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module cpu_bus_cycle_sequencer_test;
  logic clk_sys, nrst, reset_input_n, osc_running, start, branch_test, halt, irq_req, rxd;
  logic [1:0] instr_kind;
  logic [15:0] irq_vec_addr, op_addr, sp_in, x_in, addr;
  logic [7:0] acc_a, acc_b, ccr_in, data_in, data_out, cpu_rdata, rx_data;
  logic rd_write_only, rw, rd_n, wr_n, opcode_fetch_strobe_n, busy, wai_waiting;
  logic core_reset_n, rx_valid, rx_frame_err;
  int fails = 0;
  int cmp_count = 0;
  localparam int BIT_CYC = cbs_pkg::RX_TICK_DIV_I * cbs_pkg::RX_OVERSAMPLE;
  cbs_sequencer i_dut (.clk_sys(clk_sys), .nrst(nrst), .reset_input_n(reset_input_n),
    .osc_running(osc_running), .start(start), .instr_kind(instr_kind),
    .branch_test(branch_test), .halt(halt), .irq_req(irq_req), .irq_vec_addr(irq_vec_addr),
    .op_addr(op_addr), .sp_in(sp_in), .x_in(x_in), .acc_a(acc_a), .acc_b(acc_b),
    .ccr_in(ccr_in), .data_in(data_in), .rd_write_only(rd_write_only), .rxd(rxd),
    .addr(addr), .data_out(data_out), .rw(rw), .rd_n(rd_n), .wr_n(wr_n),
    .opcode_fetch_strobe_n(opcode_fetch_strobe_n), .busy(busy), .wai_waiting(wai_waiting),
    .cpu_rdata(cpu_rdata), .core_reset_n(core_reset_n), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_frame_err(rx_frame_err));
  cbs_mem_model i_mem (.clk_sys(clk_sys), .addr(addr), .data_out(data_out), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .rd_write_only(rd_write_only));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic bus(input string nm, input logic [18:0] e);
    `CHK(nm, e, {addr, rd_n, wr_n, opcode_fetch_strobe_n})
    tick(1);
  endtask : bus
  task automatic wr(input string nm, input logic [15:0] a, input logic [7:0] d);
    `CHK(nm, {a, 3'b101, 1'b0, d}, {addr, rd_n, wr_n, opcode_fetch_strobe_n, rw, data_out})
    tick(1);
  endtask : wr
  task automatic go(input logic [1:0] k, input logic t);
    instr_kind = k;
    branch_test = t;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask : go
  task automatic t_rst();
    reset_input_n = 1'b1;
    tick(5);
    `CHK("rst no osc", 1'b0, core_reset_n)
    osc_running = 1'b1;
    tick(1);
    `CHK("rst sync", 1'b0, core_reset_n)
    tick(4);
    `CHK("rst up", 1'b1, core_reset_n)
    reset_input_n = 1'b0;
    tick(5);
    `CHK("rst mid", 1'b0, core_reset_n)
    reset_input_n = 1'b1;
    tick(6);
  endtask : t_rst
  task automatic t_swi();
    logic [7:0] push [7] = '{8'h31, 8'h12, 8'h5A, 8'hA5, 8'h11, 8'h22, 8'hC3};
    go(cbs_pkg::KIND_SWI, 1'b0);
    bus("swi op", {16'h1231, 3'b011});
    bus("swi dummy", {16'hFFFF, 3'b111});
    for (int i = 0; i < 7; i++) wr("swi push", 16'h01F0 - 16'(i), push[i]);
    bus("swi vec hi", {16'hFFFA, 3'b011});
    bus("swi vec lo", {16'hFFFB, 3'b011});
    bus("swi fetch", {16'h1234, 3'b010});
    `CHK("swi busy", 1'b0, busy)
  endtask : t_swi
  task automatic t_bra();
    for (int t = 0; t < 2; t++) begin
      go(cbs_pkg::KIND_BRA, t[0]);
      bus("bra ofs", {16'h1001, 3'b011});
      bus("bra dummy", {16'hFFFF, 3'b111});
      bus("bra fetch", {(t == 1) ? 16'h0FA6 : 16'h1002, 3'b010});
    end
    go(cbs_pkg::KIND_BSR, 1'b0);
    bus("bsr ofs", {16'h1001, 3'b011});
    bus("bsr dummy", {16'hFFFF, 3'b111});
    wr("bsr lo", 16'h01F0, 8'h02);
    wr("bsr hi", 16'h01EF, 8'h10);
    bus("bsr fetch", {16'h0FA6, 3'b010});
  endtask : t_bra
  task automatic t_wo();
    op_addr = 16'h3FFF;
    go(cbs_pkg::KIND_BRA, 1'b1);
    bus("wo ofs", {16'h4000, 3'b011});
    `CHK("wo data", 8'hFF, cpu_rdata)
    bus("wo dummy", {16'hFFFF, 3'b111});
    bus("wo target", {16'h4000, 3'b010});
  endtask : t_wo
  task automatic t_wai();
    int n;
    op_addr = 16'h1230;
    go(cbs_pkg::KIND_WAI, 1'b0);
    tick(12);
    `CHK("wai wait", 1'b1, wai_waiting)
    `CHK("wai idle", 16'hFFFF, addr)
    irq_req = 1'b1;
    n = 0;
    while (!(addr === 16'h2000 && rd_n === 1'b0) && n < 4) begin
      tick(1);
      n++;
    end
    irq_req = 1'b0;
    bus("wai vec hi", {16'h2000, 3'b011});
    bus("wai vec lo", {16'h2001, 3'b011});
    bus("wai fetch", {16'hA5A4, 3'b010});
  endtask : t_wai
  task automatic t_halt();
    halt = 1'b1;
    go(cbs_pkg::KIND_BRA, 1'b0);
    `CHK("halt busy", 1'b0, busy)
    bus("halt bus", {16'hFFFF, 3'b111});
    halt = 1'b0;
  endtask : t_halt
  task automatic t_rx(input logic [7:0] d, input logic stp, input int p);
    logic seen;
    seen = 1'b0;
    rxd = 1'b0;
    tick(p);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      tick(p);
    end
    rxd = stp;
    for (int i = 0; i < p; i++) begin
      tick(1);
      seen |= rx_valid;
    end
    rxd = 1'b1;
    `CHK("rx valid", stp, seen)
    `CHK("rx ferr", !stp, rx_frame_err)
    `CHK("rx data", d, rx_data)
  endtask : t_rx
  task automatic complete_run();
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    fails++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    reset_input_n = 1'b0;
    osc_running = 1'b0;
    start = 1'b0;
    instr_kind = 2'h0;
    branch_test = 1'b0;
    halt = 1'b0;
    irq_req = 1'b0;
    irq_vec_addr = 16'h2000;
    rxd = 1'b1;
    op_addr = 16'h1230;
    sp_in = 16'h01F0;
    x_in = 16'hA55A;
    acc_a = 8'h11;
    acc_b = 8'h22;
    ccr_in = 8'hC3;
    tick(12);
    nrst = 1'b1;
    t_rst();
    t_swi();
    op_addr = 16'h1000;
    t_bra();
    t_wo();
    t_wai();
    t_halt();
    t_rx(8'h5A, 1'b1, BIT_CYC);
    t_rx(8'hC3, 1'b1, BIT_CYC * 104 / 100);
    t_rx(8'h96, 1'b0, BIT_CYC);
    complete_run();
  end
endmodule : cpu_bus_cycle_sequencer_test
